// *** rtl/mii_port4.sv ***
// Port-4 MII data path, straps and hardware status pins
`timescale 1ns/1ns
module mii_port4
(
  input  wire logic                              CLK_IN,
  input  wire logic                              RESETN_IN,
  input  wire logic                              CE_IN,
  input  wire logic                              PORT4_TX_CLOCK_IN,
  input  wire logic                              PORT4_RX_CLOCK_IN,
  input  wire logic [mii_port4_pkg::NIB_W-1:0]   PORT4_TX_NIBBLE_IN,
  output logic      [mii_port4_pkg::NIB_W-1:0]   PORT4_TX_NIBBLE_OUT,
  output logic      [mii_port4_pkg::NIB_W-1:0]   PORT4_TX_NIBBLE_OE_OUT,
  output logic                                   PORT4_TX_ENABLE_OUT,
  input  wire logic [mii_port4_pkg::NIB_W-1:0]   PORT4_RX_NIBBLE_IN,
  input  wire logic                              PORT4_RX_VALID_IN,
  input  wire logic                              PORT4_RX_ERROR_IN,
  input  wire logic                              PORT4_COLLISION_IN,
  input  wire logic                              PORT4_CARRIER_IN,
  input  wire logic                              PORT4_DUPLEX_IN,
  input  wire logic                              PORT4_LINK_FAIL_IN,
  input  wire logic                              PORT4_SPEED_IN,
  input  wire logic                              PORT4_FIBER_SELECT_IN,
  input  wire logic [mii_port4_pkg::NIB_W-1:0]   TX_DATA_IN,
  input  wire logic                              TX_VALID_IN,
  output logic                                   TX_READY_OUT,
  output logic      [mii_port4_pkg::NIB_W-1:0]   RX_DATA_OUT,
  output logic                                   RX_VALID_OUT,
  output logic                                   RX_ERROR_OUT,
  output logic                                   COLLISION_OUT,
  output logic                                   CARRIER_OUT,
  output logic                                   FULL_DUPLEX_OUT,
  output logic                                   LINK_UP_OUT,
  output logic                                   SPEED_100_OUT,
  output logic                                   FIBER_MODE_OUT,
  output logic      [mii_port4_pkg::STRAP_W-1:0] PORT_TYPE_OUT,
  output logic                                   STRAPS_DONE_OUT
);
  import mii_port4_pkg::*;

  pin_sync_if #(.W(PIN_W)) sif ();   // Pin levels to and from synchroniser
  pin_vec_t                p;        // Synchronised pin levels

  // Every pin enters through the same two-flop stage, so all line up in time
  pin_sync #(.W(PIN_W)) u_sync
  (
    .clk_in    (CLK_IN),
    .resetn_in (RESETN_IN),
    .ce_in     (CE_IN),
    .pins      (sif)
  );

  // Gather raw pins; link clocks sampled like data
  always_comb
  begin
    p         = pin_vec_t'(sif.synced);
    sif.raw   = {PORT4_TX_CLOCK_IN, PORT4_RX_CLOCK_IN, PORT4_RX_NIBBLE_IN,
                 PORT4_RX_VALID_IN, PORT4_RX_ERROR_IN, PORT4_COLLISION_IN,
                 PORT4_CARRIER_IN, PORT4_TX_NIBBLE_IN[STRAP_W-1:0],
                 PORT4_DUPLEX_IN, PORT4_LINK_FAIL_IN, PORT4_SPEED_IN,
                 PORT4_FIBER_SELECT_IN};
  end

  // Power-on strap capture
  boot_state_t          boot_ff;      // Strap sequence state
  boot_state_t          nxt_boot;
  logic [1:0]           settle_ff;    // Cycles since reset release
  logic [1:0]           nxt_settle;
  logic [STRAP_W-1:0]   strap_ff;     // Latched port type
  logic [STRAP_W-1:0]   nxt_strap;

  // Wait for synchronised strap levels, capture once, then run
  always_comb
  begin
    nxt_boot   = boot_ff;
    nxt_settle = settle_ff;
    nxt_strap  = strap_ff;
    if (CE_IN)
    begin
      case (boot_ff)
        ST_SETTLE:
        begin
          // Pins not driven yet; the pulls decide the strap level
          if (settle_ff == SETTLE_CYCLES)
            nxt_boot = ST_CAPTURE;
          else
            nxt_settle = settle_ff + 2'h1;
        end
        ST_CAPTURE:
        begin
          nxt_strap[0] = p.strap[0];
          nxt_strap[1] = p.strap[1];
          nxt_boot     = ST_RUN;
        end
        ST_RUN:
        begin
          // Strap held until next reset
          nxt_strap = strap_ff;
        end
        default:
          nxt_boot = ST_SETTLE;
      endcase
    end
  end

  // Strap registers
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      boot_ff   <= ST_SETTLE;
      settle_ff <= SETTLE_RESET;
      strap_ff  <= STRAP_RESET;
    end
    else
    begin
      boot_ff   <= nxt_boot;
      settle_ff <= nxt_settle;
      strap_ff  <= nxt_strap;
    end
  end

  // Link clock edges and data path
  logic              txclk_prev_ff;   // Last sampled transmit clock
  logic              rxclk_prev_ff;   // Last sampled receive clock
  logic              tx_rise;         // Transmit clock rising edge seen
  logic              rx_rise;         // Receive clock rising edge seen
  logic              running;         // Straps taken, pins are ours
  logic              link_up;         // Link-fail pin low
  logic [NIB_W-1:0]  tx_nib_ff;       // Nibble on the transmit pins
  logic              tx_en_ff;        // Transmit enable pin
  logic              oe_ff;           // Output enable of transmit pins
  logic [NIB_W-1:0]  rx_nib_ff;       // Last received nibble
  logic              rx_valid_ff;     // One-cycle receive strobe
  logic              rx_err_ff;       // One-cycle error strobe
  logic [5:0]        status_ff;       // Registered status levels
  logic [NIB_W-1:0]  nxt_tx_nib;
  logic              nxt_tx_en;
  logic              nxt_oe;
  logic [NIB_W-1:0]  nxt_rx_nib;
  logic              nxt_rx_valid;
  logic              nxt_rx_err;
  logic [5:0]        nxt_status;

  assign tx_rise = p.tx_clk & ~txclk_prev_ff;
  assign rx_rise = p.rx_clk & ~rxclk_prev_ff;
  assign running = (boot_ff == ST_RUN);
  assign link_up = ~p.link_fail;

  // Nibble taken from the user on a transmit clock rise while link is up
  assign TX_READY_OUT = CE_IN & running & tx_rise & link_up;

  // Next values of the data path
  always_comb
  begin
    nxt_tx_nib   = tx_nib_ff;
    nxt_tx_en    = tx_en_ff;
    nxt_oe       = oe_ff;
    nxt_rx_nib   = rx_nib_ff;
    nxt_rx_valid = 1'b0;
    nxt_rx_err   = 1'b0;
    nxt_status   = status_ff;
    if (CE_IN)
    begin
      // Drive the pins only once the straps are latched
      nxt_oe = running;
      if (running && tx_rise)
      begin
        // Update only on the rising edge, so the partner sees a stable cycle
        nxt_tx_en  = TX_VALID_IN & link_up;
        nxt_tx_nib = (TX_VALID_IN && link_up) ? TX_DATA_IN : IDLE_NIBBLE;
      end
      if (rx_rise)
      begin
        // Error reported even outside valid, as carrier errors
        nxt_rx_nib   = p.rx_dv ? p.rxd : rx_nib_ff;
        nxt_rx_valid = p.rx_dv;
        nxt_rx_err   = p.rx_er;
      end
      // Collision only means something in half duplex
      nxt_status = {p.col & p.duplex, p.crs,
                    ~p.duplex,
                    link_up,
                    ~p.speed,
                    p.fiber};
    end
  end

  // Data path registers
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      txclk_prev_ff <= 1'b0;
      rxclk_prev_ff <= 1'b0;
      tx_nib_ff     <= NIBBLE_RESET;
      tx_en_ff      <= 1'b0;
      oe_ff         <= 1'b0;
      rx_nib_ff     <= NIBBLE_RESET;
      rx_valid_ff   <= 1'b0;
      rx_err_ff     <= 1'b0;
      status_ff     <= 6'h00;
    end
    else
    begin
      txclk_prev_ff <= CE_IN ? p.tx_clk : txclk_prev_ff;
      rxclk_prev_ff <= CE_IN ? p.rx_clk : rxclk_prev_ff;
      tx_nib_ff     <= nxt_tx_nib;
      tx_en_ff      <= nxt_tx_en;
      oe_ff         <= nxt_oe;
      rx_nib_ff     <= nxt_rx_nib;
      rx_valid_ff   <= nxt_rx_valid;
      rx_err_ff     <= nxt_rx_err;
      status_ff     <= nxt_status;
    end
  end

  // Outputs, all from flip-flops except the ready handshake and STRAPS_DONE_OUT, which is decoded from the strap state
  assign PORT4_TX_NIBBLE_OUT    = tx_nib_ff;
  assign PORT4_TX_NIBBLE_OE_OUT = {NIB_W{oe_ff}};
  assign PORT4_TX_ENABLE_OUT    = tx_en_ff;
  assign RX_DATA_OUT            = rx_nib_ff;
  assign RX_VALID_OUT           = rx_valid_ff;
  assign RX_ERROR_OUT           = rx_err_ff;
  assign COLLISION_OUT          = status_ff[5];
  assign CARRIER_OUT            = status_ff[4];
  assign FULL_DUPLEX_OUT        = status_ff[3];
  assign LINK_UP_OUT            = status_ff[2];
  assign SPEED_100_OUT          = status_ff[1];
  assign FIBER_MODE_OUT         = status_ff[0];
  assign PORT_TYPE_OUT          = strap_ff;
  assign STRAPS_DONE_OUT        = running;

  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence capture_s;
    boot_ff == ST_CAPTURE && CE_IN;
  endsequence

  sequence tx_take_s;
    CE_IN && running && tx_rise && TX_VALID_IN && link_up;
  endsequence

  tx_nibble_edge_a: assert property (
    $changed(tx_nib_ff) |-> $past(tx_rise && CE_IN))
    else $error("transmit nibble changed off a clock rise");
  tx_enable_a: assert property (
    tx_take_s |=> tx_en_ff && tx_nib_ff == $past(TX_DATA_IN))
    else $error("accepted nibble not driven with enable");
  rx_sample_a: assert property (
    (CE_IN && rx_rise && p.rx_dv) |=> RX_VALID_OUT && RX_DATA_OUT == $past(p.rxd))
    else $error("receive nibble not sampled on clock rise");
  fiber_mode_a: assert property (
    CE_IN |=> FIBER_MODE_OUT == $past(p.fiber))
    else $error("fiber mode does not follow select pin");
  duplex_map_a: assert property (
    CE_IN |=> FULL_DUPLEX_OUT == !$past(p.duplex))
    else $error("duplex mapping wrong");
  link_map_a: assert property (
    CE_IN |=> LINK_UP_OUT == !$past(p.link_fail))
    else $error("link mapping wrong");
  speed_map_a: assert property (
    CE_IN |=> SPEED_100_OUT == !$past(p.speed))
    else $error("speed mapping wrong");
  strap_bit0_a: assert property (
    capture_s |=> strap_ff[0] == $past(p.strap[0]) && running)
    else $error("type bit 0 not captured");
  strap_bit1_a: assert property (
    capture_s |=> strap_ff[1] == $past(p.strap[1]))
    else $error("type bit 1 not captured");
  strap_hold_a: assert property (
    running |=> $stable(strap_ff) && running)
    else $error("straps changed after capture");
  drive_after_a: assert property (
    oe_ff |-> $past(running))
    else $error("pins driven before strap capture");

endmodule

// *** rtl/mii_port4_pkg.sv ***
// Shared constants and types for the port-4 MII block
package mii_port4_pkg;

  localparam int          NIB_W          = 4;     // MII nibble width
  localparam int          STRAP_W        = 2;     // Port type strap bits
  localparam int          CLK_PERIOD_NS  = 10;    // Core clock period
  localparam int          SETTLE_NS      = 30;    // Strap settle time after reset release
  localparam logic [1:0]  SETTLE_CYCLES  = 2'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0]  SETTLE_RESET   = 2'h0;  // Settle counter after reset
  localparam logic [3:0]  NIBBLE_RESET   = 4'h0;  // Nibble registers after reset
  localparam logic [1:0]  STRAP_RESET    = 2'h0;  // Strap register after reset
  localparam logic [3:0]  IDLE_NIBBLE    = 4'h0;  // Nibble driven outside frames

  // Pin inputs gathered for the synchroniser, in one packed word
  typedef struct packed
  {
    logic             tx_clk;     // Transmit clock from partner
    logic             rx_clk;     // Receive clock from partner
    logic [NIB_W-1:0] rxd;        // Receive nibble
    logic             rx_dv;      // Receive data valid
    logic             rx_er;      // Receive error
    logic             col;        // Collision
    logic             crs;        // Carrier sense
    logic [STRAP_W-1:0] strap;    // Transmit pins read back as straps
    logic             duplex;     // High means half duplex
    logic             link_fail;  // High means link down
    logic             speed;      // High means 10M
    logic             fiber;      // High means fiber mode
  } pin_vec_t;

  localparam int PIN_W = $bits(pin_vec_t);

  // Power-on sequence of the strap pins
  typedef enum logic [1:0]
  {
    ST_SETTLE,
    ST_CAPTURE,
    ST_RUN
  } boot_state_t;

endpackage

// *** rtl/pin_sync_if.sv ***
// Carrier between the pin synchroniser and the port logic
`timescale 1ns/1ns
interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;     // Asynchronous pin levels
  logic [W-1:0] synced;  // Levels after two flip-flops

  modport port_side (output raw, input synced);
  modport sync_side (input raw, output synced);
endinterface

// *** rtl/pin_sync.sv ***
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module pin_sync #(parameter int W = 1)
(
  input  wire logic   clk_in,
  input  wire logic   resetn_in,
  input  wire logic   ce_in,
  pin_sync_if.sync_side pins
);

  logic [W-1:0] meta_ff;   // First stage, read only by second stage
  logic [W-1:0] sync_ff;   // Second stage, safe to use
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // Next values, held while the clock enable is low
  always_comb
  begin
    nxt_meta = ce_in ? pins.raw : meta_ff;
    nxt_sync = ce_in ? meta_ff  : sync_ff;
  end

  // Registers only
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign pins.synced = sync_ff;

endmodule

// *** dv/mii_phy_model.sv ***
// Behavioural partner on the far side of the port-4 MII: clocks, receive pins, strap pins
`timescale 1ns/1ns
module mii_phy_model
(
  input  wire logic       tx_run_in,      // Let the transmit clock run
  input  wire logic       rx_run_in,      // Let the receive clock run
  input  wire logic [1:0] strap_in,       // Board strap levels on transmit bits 1:0
  input  wire logic       col_req_in,     // Requested collision level
  input  wire logic       crs_req_in,     // Requested carrier level
  input  wire logic [3:0] tx_nibble_in,   // Device transmit nibble drive
  input  wire logic [3:0] tx_oe_in,       // Device transmit output enables
  input  wire logic       tx_enable_in,   // Device transmit enable
  output logic            tx_clk_out,     // Transmit clock toward the device
  output logic            rx_clk_out,     // Receive clock toward the device
  output logic      [3:0] rx_nibble_out,  // Receive nibble pins
  output logic            rx_valid_out,   // Receive data valid pin
  output logic            rx_error_out,   // Receive error pin
  output logic            col_out,        // Collision pin
  output logic            crs_out,        // Carrier sense pin
  output logic      [3:0] tx_pin_out,     // Resolved level on the transmit pins
  output logic     [15:0] tx_log_out,     // Last four nibbles taken with enable
  output logic      [7:0] tx_count_out    // Nibbles taken with enable
);
  // Clocks stand still low outside frames; a cycle always completes
  initial
  begin
    tx_clk_out = 1'b0;
    forever
    begin
      wait (tx_run_in);
      #40 tx_clk_out = 1'b1;
      #40 tx_clk_out = 1'b0;
    end
  end

  initial
  begin
    rx_clk_out = 1'b0;
    forever
    begin
      wait (rx_run_in);
      #40 rx_clk_out = 1'b1;
      #40 rx_clk_out = 1'b0;
    end
  end

  // Receive pins idle at the pull-down level
  initial
  begin
    rx_nibble_out = 4'h0;
    rx_valid_out  = 1'b0;
    rx_error_out  = 1'b0;
  end

  // Pins change on the falling clock so they are steady at the rise
  task automatic rx_send(input logic [3:0] d, input logic dv, input logic er);
    @(negedge rx_clk_out);
    rx_nibble_out = d;
    rx_valid_out  = dv;
    rx_error_out  = er;
  endtask

  // Status lines follow the bench request
  assign col_out = col_req_in;
  assign crs_out = crs_req_in;

  // Undriven transmit pins fall back to the strap or the pull-down
  assign tx_pin_out = (tx_oe_in & tx_nibble_in) | (~tx_oe_in & {2'h0, strap_in});

  // Take the transmit nibble at our own clock rise, as a real PHY does
  // One process owns the log, so each output has a single driver
  initial
  begin
    tx_log_out   = 16'h0;
    tx_count_out = 8'h0;
    forever
    begin
      @(posedge tx_clk_out);
      if (tx_enable_in === 1'b1)
      begin
        tx_log_out   = {tx_log_out[11:0], tx_nibble_in};
        tx_count_out = tx_count_out + 8'h1;
      end
    end
  end
endmodule

// *** dv/port4_mii_interface_tb_top.sv ***
// Self-checking bench for the port-4 MII block with its partner model
`timescale 1ns/1ns
module port4_mii_interface_tb_top;
  logic CLK_IN, RESETN_IN, TX_VALID_IN, tx_run, rx_run, col_req, crs_req, ce;
  logic PORT4_DUPLEX_IN, PORT4_LINK_FAIL_IN, PORT4_SPEED_IN, PORT4_FIBER_SELECT_IN;
  logic [3:0] TX_DATA_IN, b;
  logic [1:0] strap;
  logic [5:0] st;
  wire logic tx_clk, rx_clk, rx_dv, rx_er, col, crs, TX_READY_OUT, RX_VALID_OUT, RX_ERROR_OUT;
  wire logic tx_en, COLLISION_OUT, CARRIER_OUT, FULL_DUPLEX_OUT, LINK_UP_OUT, SPEED_100_OUT;
  wire logic FIBER_MODE_OUT, STRAPS_DONE_OUT;
  wire logic [3:0] rxd, tx_nib, tx_oe, tx_pin, RX_DATA_OUT;
  wire logic [1:0] PORT_TYPE_OUT;
  wire logic [15:0] tx_log;
  wire logic [7:0] tx_count;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;

  mii_port4 DUT (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .CE_IN(ce),
    .PORT4_TX_CLOCK_IN(tx_clk), .PORT4_RX_CLOCK_IN(rx_clk), .PORT4_TX_NIBBLE_IN(tx_pin),
    .PORT4_TX_NIBBLE_OUT(tx_nib), .PORT4_TX_NIBBLE_OE_OUT(tx_oe), .PORT4_TX_ENABLE_OUT(tx_en),
    .PORT4_RX_NIBBLE_IN(rxd), .PORT4_RX_VALID_IN(rx_dv), .PORT4_RX_ERROR_IN(rx_er),
    .PORT4_COLLISION_IN(col), .PORT4_CARRIER_IN(crs), .PORT4_DUPLEX_IN(PORT4_DUPLEX_IN),
    .PORT4_LINK_FAIL_IN(PORT4_LINK_FAIL_IN), .PORT4_SPEED_IN(PORT4_SPEED_IN),
    .PORT4_FIBER_SELECT_IN(PORT4_FIBER_SELECT_IN), .TX_DATA_IN(TX_DATA_IN),
    .TX_VALID_IN(TX_VALID_IN), .TX_READY_OUT(TX_READY_OUT), .RX_DATA_OUT(RX_DATA_OUT),
    .RX_VALID_OUT(RX_VALID_OUT), .RX_ERROR_OUT(RX_ERROR_OUT), .COLLISION_OUT(COLLISION_OUT),
    .CARRIER_OUT(CARRIER_OUT), .FULL_DUPLEX_OUT(FULL_DUPLEX_OUT), .LINK_UP_OUT(LINK_UP_OUT),
    .SPEED_100_OUT(SPEED_100_OUT), .FIBER_MODE_OUT(FIBER_MODE_OUT),
    .PORT_TYPE_OUT(PORT_TYPE_OUT), .STRAPS_DONE_OUT(STRAPS_DONE_OUT));

  mii_phy_model partner (.tx_run_in(tx_run), .rx_run_in(rx_run), .strap_in(strap),
    .col_req_in(col_req), .crs_req_in(crs_req), .tx_nibble_in(tx_nib), .tx_oe_in(tx_oe),
    .tx_enable_in(tx_en), .tx_clk_out(tx_clk), .rx_clk_out(rx_clk), .rx_nibble_out(rxd),
    .rx_valid_out(rx_dv), .rx_error_out(rx_er), .col_out(col), .crs_out(crs),
    .tx_pin_out(tx_pin), .tx_log_out(tx_log), .tx_count_out(tx_count));

  // Core clock, 10 ns period
  initial
  begin
    CLK_IN = 1'b0;
    forever #5 CLK_IN = ~CLK_IN;
  end

  // Single comparison point; mismatches reported at once
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge CLK_IN)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      stop_test();
    end
  end

  // Bounded wait for the straps to be taken
  task automatic wait_done();
    for (int n = 0; n < 30 && STRAPS_DONE_OUT !== 1'b1; n++)
      @(negedge CLK_IN);
    @(negedge CLK_IN);
  endtask

  // Offer one nibble and hold it until the ready edge takes it
  task automatic tx_send(input logic [3:0] d);
    @(negedge CLK_IN);
    TX_DATA_IN  = d;
    TX_VALID_IN = 1'b1;
    #1;
    for (int n = 0; n < 40 && TX_READY_OUT !== 1'b1; n++)
    begin
      @(negedge CLK_IN);
      #1;
    end
    check({15'h0, TX_READY_OUT}, 16'h1);
    @(posedge CLK_IN);
  endtask

  // Wait for the next receive strobe and compare valid, error and data
  task automatic rx_expect(input logic [5:0] exp);
    for (int n = 0; n < 30 && (RX_VALID_OUT | RX_ERROR_OUT) !== 1'b1; n++)
      @(negedge CLK_IN);
    check({10'h0, RX_VALID_OUT, RX_ERROR_OUT, RX_DATA_OUT}, {10'h0, exp});
    @(negedge CLK_IN);
  endtask

  initial
  begin
    // Every input defined at time zero, link up, full duplex, 100M
    RESETN_IN = 1'b0;
    TX_VALID_IN = 1'b0;
    TX_DATA_IN = 4'h0;
    ce = 1'b1;
    {tx_run, rx_run, col_req, crs_req} = 4'h0;
    {PORT4_DUPLEX_IN, PORT4_LINK_FAIL_IN, PORT4_SPEED_IN, PORT4_FIBER_SELECT_IN} = 4'h0;
    strap = 2'h2;
    b = 4'h0;
    repeat (20) @(negedge CLK_IN);
    check({11'h0, STRAPS_DONE_OUT, tx_oe}, 16'h0);
    RESETN_IN = 1'b1;
    wait_done();
    check({13'h0, STRAPS_DONE_OUT, PORT_TYPE_OUT}, 16'h6);
    @(negedge CLK_IN);
    check({12'h0, tx_oe}, 16'hf);
    // Straps moving after capture must be ignored
    strap = 2'h1;
    repeat (10) @(negedge CLK_IN);
    check({14'h0, PORT_TYPE_OUT}, 16'h2);
    // Every combination of the hardware status pins
    for (int i = 0; i < 16; i++)
    begin
      b = 4'(i);
      {PORT4_DUPLEX_IN, PORT4_LINK_FAIL_IN, PORT4_SPEED_IN, PORT4_FIBER_SELECT_IN} = b;
      col_req = 1'b1;
      crs_req = b[0];
      repeat (5) @(negedge CLK_IN);
      st = {FULL_DUPLEX_OUT, LINK_UP_OUT, SPEED_100_OUT, FIBER_MODE_OUT,
            COLLISION_OUT, CARRIER_OUT};
      check({10'h0, st}, {10'h0, ~b[3:1], b[0], b[3], b[0]});
    end
    {PORT4_DUPLEX_IN, PORT4_LINK_FAIL_IN, PORT4_SPEED_IN, PORT4_FIBER_SELECT_IN} = 4'h0;
    {col_req, crs_req} = 2'h0;
    // Clock enable low freezes every register but the receive strobes, which clear; synchronisers included
    ce = 1'b0;
    repeat (5) @(negedge CLK_IN);
    check({15'h0, FIBER_MODE_OUT}, 16'h1);
    ce = 1'b1;
    repeat (5) @(negedge CLK_IN);
    check({15'h0, FIBER_MODE_OUT}, 16'h0);
    // Back-to-back receive nibbles, a nibble without valid, then error nibbles with and without valid
    rx_run = 1'b1;
    fork
      begin
        partner.rx_send(4'h9, 1'b1, 1'b0);
        partner.rx_send(4'h6, 1'b1, 1'b0);
        partner.rx_send(4'hf, 1'b1, 1'b0);
        partner.rx_send(4'h1, 1'b1, 1'b0);
        partner.rx_send(4'h7, 1'b0, 1'b0);
        partner.rx_send(4'hc, 1'b1, 1'b1);
        partner.rx_send(4'h5, 1'b0, 1'b1);
        partner.rx_send(4'h0, 1'b0, 1'b0);
      end
      begin
        rx_expect(6'h29);
        rx_expect(6'h26);
        rx_expect(6'h2f);
        rx_expect(6'h21);
        rx_expect(6'h3c);
        rx_expect(6'h1c);
      end
    join
    rx_run = 1'b0;
    // Three nibbles back to back, then an idle clock rise
    tx_run = 1'b1;
    tx_send(4'h5);
    tx_send(4'ha);
    tx_send(4'h3);
    @(negedge CLK_IN);
    TX_VALID_IN = 1'b0;
    repeat (24) @(negedge CLK_IN);
    check({tx_log[11:0], tx_count[3:0]}, 16'h5a33);
    check({11'h0, tx_en, tx_nib}, 16'h0);
    // Link down: a pending nibble must never be taken
    PORT4_LINK_FAIL_IN = 1'b1;
    repeat (4) @(negedge CLK_IN);
    TX_VALID_IN = 1'b1;
    b = 4'h0;
    repeat (24)
    begin
      @(negedge CLK_IN);
      b[0] = b[0] | (TX_READY_OUT !== 1'b0);
    end
    check({12'h0, b}, 16'h0);
    TX_VALID_IN = 1'b0;
    tx_run = 1'b0;
    // Second reset takes the new strap levels
    RESETN_IN = 1'b0;
    repeat (3) @(negedge CLK_IN);
    check({11'h0, STRAPS_DONE_OUT, tx_oe}, 16'h0);
    RESETN_IN = 1'b1;
    wait_done();
    check({13'h0, STRAPS_DONE_OUT, PORT_TYPE_OUT}, 16'h5);
    stop_test();
  end
endmodule
